// ==== src/lvds_tx_pkg.sv ====
// Constants shared by the display link serializer and its lane shifters.
// Assumes a system clock (CLK) that stands in for the bit-rate clock of the PLL.
// Behaviour
// - Accept a 28-bit word per pixel clock; spread it over four data lanes. Code captures a word only once the previous hand-over is acknowledged.
// - Send a clock locked to the pixel clock on a fifth lane.
// - Word holds 24 colour bits, line sync, frame sync, data valid, control bit.
// - Each data lane carries seven serial bits per pixel clock period.
// - Capture the parallel word on the falling pixel clock edge.
// - Seven equally spaced bit slots 0 to 6 per period on every lane.
// - Serial output is not valid until the PLL lock time has passed.
package lvds_tx_pkg;

  // ----------------------------------------------------------------------
  // Word layout
  // ----------------------------------------------------------------------
  localparam int          WORD_WIDTH      = 28;
  localparam int          COLOUR_WIDTH    = 24;
  localparam int          LANE_COUNT      = 4;
  localparam int          SLOT_COUNT      = 7;
  localparam int          LINE_SYNC_POS   = 24;
  localparam int          FRAME_SYNC_POS  = 25;
  localparam int          DATA_VALID_POS  = 26;
  localparam int          CONTROL_POS     = 27;

  // ----------------------------------------------------------------------
  // Slot sequencing
  // ----------------------------------------------------------------------
  localparam logic [2:0]  SLOT_FIRST      = 3'h0;
  localparam logic [2:0]  SLOT_LAST       = 3'h6;
  localparam logic [6:0]  CLOCK_LANE_PATTERN = 7'h63;
  localparam logic [6:0]  IDLE_SLOTS      = 7'h00;

  // ----------------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------------
  localparam int          CLK_PERIOD_NS   = 40;
  localparam int          LOCK_TIME_MS    = 10;
  localparam int          LOCK_TIME_NS    = LOCK_TIME_MS * 1000000;
  localparam int          LOCK_CYCLES     = LOCK_TIME_NS / CLK_PERIOD_NS;
  localparam int          PIXEL_PERIOD_MAX_NS = 50;

  typedef enum logic {PLL_ACQUIRE, PLL_LOCK} pll_state_t;

endpackage

// ==== src/lane_serializer.sv ====
// One serial lane: loads seven slots at once and shifts them out slot 0 first.
// Assumes the caller pulses load once every seven clocks.
`timescale 1ns/1ps
`default_nettype none
module lane_serializer
  import lvds_tx_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       arst_n,
  input  wire logic       load,
  input  wire logic [6:0] slots,
  output var  logic       serial_out
);

  logic [6:0] shreg;

  // ----------------------------------------------------------------------
  // Shift register
  // ----------------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shreg <= IDLE_SLOTS;
    end else if (load) begin
      shreg <= slots;
    end else begin
      shreg <= {1'b0, shreg[6:1]};
    end
  end

  assign serial_out = shreg[0];

endmodule
`default_nettype wire

// ==== src/lvds_display_serializer_tx.sv ====
// Transmit end of a display serial link: captures pixel words and serializes
// them onto four data lanes plus a forwarded clock lane.
// Assumes CLK is the bit-slot clock and ARST_N is the power-down input.
`timescale 1ns/1ps
`default_nettype none
module lvds_display_serializer_tx
  import lvds_tx_pkg::*;
#(
  parameter int LOCK_WAIT = LOCK_CYCLES
)
(
  input  wire logic        CLK,
  input  wire logic        ARST_N,
  input  wire logic        PIXEL_CLOCK_IN,
  input  wire logic [23:0] PARALLEL_PIXEL_IN,
  input  wire logic        LINE_SYNC,
  input  wire logic        FRAME_SYNC,
  input  wire logic        PIXEL_DATA_VALID,
  input  wire logic        GENERAL_CONTROL_BIT,
  output var  logic [3:0]  SERIAL_LANE_OUT,
  output var  logic [3:0]  SERIAL_LANE_OE,
  output var  logic        LINK_CLOCK_OUT,
  output var  logic        LINK_CLOCK_OE,
  output var  logic        PLL_LOCKED
);

  // ----------------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------------
  function automatic logic [6:0] lane_slice(input logic [WORD_WIDTH-1:0] word,
                                            input int                    lane);
    lane_slice = word[lane*SLOT_COUNT +: SLOT_COUNT];
  endfunction

  // ----------------------------------------------------------------------
  // Pixel clock domain reset
  // ----------------------------------------------------------------------
  logic pix_rst_meta;
  logic pix_rst_n;

  always_ff @(negedge PIXEL_CLOCK_IN or negedge ARST_N) begin
    if (!ARST_N) begin
      pix_rst_meta <= 1'b0;
      pix_rst_n    <= 1'b0;
    end else begin
      pix_rst_meta <= 1'b1;
      pix_rst_n    <= pix_rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Word assembly
  // ----------------------------------------------------------------------
  logic [WORD_WIDTH-1:0] pixel_word;

  always_comb begin
    pixel_word                    = '0;
    pixel_word[COLOUR_WIDTH-1:0]  = PARALLEL_PIXEL_IN;
    pixel_word[LINE_SYNC_POS]     = LINE_SYNC;
    pixel_word[FRAME_SYNC_POS]    = FRAME_SYNC;
    pixel_word[DATA_VALID_POS]    = PIXEL_DATA_VALID;
    pixel_word[CONTROL_POS]       = GENERAL_CONTROL_BIT;
  end

  // ----------------------------------------------------------------------
  // Acknowledge return into the pixel domain
  // ----------------------------------------------------------------------
  logic ack;
  logic ack_meta;
  logic ack_sync;

  always_ff @(negedge PIXEL_CLOCK_IN or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      ack_meta <= 1'b0;
      ack_sync <= 1'b0;
    end else begin
      ack_meta <= ack;
      ack_sync <= ack_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Falling-edge capture and hand-over request
  // ----------------------------------------------------------------------
  logic                  req;
  logic [WORD_WIDTH-1:0] hold_word;

  always_ff @(negedge PIXEL_CLOCK_IN or negedge pix_rst_n) begin
    if (!pix_rst_n) begin
      req       <= 1'b0;
      hold_word <= '0;
    end else if (req == ack_sync) begin
      hold_word <= pixel_word;
      req       <= ~req;
    end
  end

  // ----------------------------------------------------------------------
  // Request crossing into the slot clock domain
  // ----------------------------------------------------------------------
  logic req_meta;
  logic req_sync;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      req_meta <= 1'b0;
      req_sync <= 1'b0;
    end else begin
      req_meta <= req;
      req_sync <= req_meta;
    end
  end

  logic                  new_word;
  logic [WORD_WIDTH-1:0] pending_word;

  assign new_word = (req_sync != ack);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      ack          <= 1'b0;
      pending_word <= '0;
    end else if (new_word) begin
      ack          <= req_sync;
      pending_word <= hold_word;
    end
  end

  // ----------------------------------------------------------------------
  // PLL lock model
  // ----------------------------------------------------------------------
  pll_state_t  pll_state;
  logic        clock_seen;
  logic [31:0] lock_count;

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      clock_seen <= 1'b0;
    end else if (new_word) begin
      clock_seen <= 1'b1;
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      pll_state  <= PLL_ACQUIRE;
      lock_count <= '0;
    end else begin
      unique case (pll_state)
        PLL_ACQUIRE: begin
          if (clock_seen) begin
            if (lock_count >= 32'(LOCK_WAIT - 1)) begin
              pll_state <= PLL_LOCK;
            end else begin
              lock_count <= lock_count + 32'h1;
            end
          end
        end
        PLL_LOCK: begin
          lock_count <= lock_count;
        end
      endcase
    end
  end

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PLL_LOCKED <= 1'b0;
    end else begin
      PLL_LOCKED <= (pll_state == PLL_LOCK);
    end
  end

  // ----------------------------------------------------------------------
  // Slot counter
  // ----------------------------------------------------------------------
  logic [2:0] slot;
  logic       load;

  assign load = (slot == SLOT_LAST);

  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      slot <= SLOT_LAST;
    end else if (load) begin
      slot <= SLOT_FIRST;
    end else begin
      slot <= slot + 3'h1;
    end
  end

  // ----------------------------------------------------------------------
  // Lanes
  // ----------------------------------------------------------------------
  logic                  locked_now;
  logic [WORD_WIDTH-1:0] send_word;
  logic [3:0]            lane_bits;
  logic                  clock_bit;

  assign locked_now = (pll_state == PLL_LOCK);
  assign send_word  = locked_now ? pending_word : '0;

  for (genvar k = 0; k < LANE_COUNT; k++) begin : g_lane
    lane_serializer u_lane (
      .clk        (CLK),
      .arst_n     (ARST_N),
      .load       (load),
      .slots      (lane_slice(send_word, k)),
      .serial_out (lane_bits[k])
    );
  end

  lane_serializer u_clock_lane (
    .clk        (CLK),
    .arst_n     (ARST_N),
    .load       (load),
    .slots      (locked_now ? CLOCK_LANE_PATTERN : IDLE_SLOTS),
    .serial_out (clock_bit)
  );

  always_comb begin
    SERIAL_LANE_OUT = lane_bits;
    LINK_CLOCK_OUT  = clock_bit;
  end

  // ----------------------------------------------------------------------
  // Output enables
  // ----------------------------------------------------------------------
  always_ff @(posedge CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      SERIAL_LANE_OE <= 4'h0;
      LINK_CLOCK_OE  <= 1'b0;
    end else begin
      SERIAL_LANE_OE <= 4'hf;
      LINK_CLOCK_OE  <= 1'b1;
    end
  end

endmodule
`default_nettype wire

// ==== verification/lvds_tx_monitor.sv ====
// Port-level checks on the display link serializer.
// Assumes it is bound to the serializer top module.
`timescale 1ns/1ps
`default_nettype none
module lvds_tx_monitor #(
  parameter int LOCK_WAIT = 20
)
(
  input wire logic        CLK,
  input wire logic        ARST_N,
  input wire logic        PIXEL_CLOCK_IN,
  input wire logic [23:0] PARALLEL_PIXEL_IN,
  input wire logic        LINE_SYNC,
  input wire logic        FRAME_SYNC,
  input wire logic        PIXEL_DATA_VALID,
  input wire logic        GENERAL_CONTROL_BIT,
  input wire logic [3:0]  SERIAL_LANE_OUT,
  input wire logic [3:0]  SERIAL_LANE_OE,
  input wire logic        LINK_CLOCK_OUT,
  input wire logic        LINK_CLOCK_OE,
  input wire logic        PLL_LOCKED
);
  localparam int LOCK_MAX = LOCK_WAIT + 60;
  default clocking @(posedge CLK); endclocking
  default disable iff (!ARST_N);
  // ----
  // Checks
  // ----
  a_pd_floats: assert property (disable iff (1'b0) !ARST_N |-> SERIAL_LANE_OE == 4'h0)
    else $error("lanes driven in power-down");
  a_pd_clears: assert property (disable iff (1'b0) !ARST_N |-> !PLL_LOCKED && !LINK_CLOCK_OE)
    else $error("lock or clock lane kept in power-down");
  a_oe_after_release: assert property ($past(ARST_N) |-> SERIAL_LANE_OE == 4'hf && LINK_CLOCK_OE)
    else $error("outputs not driven after release");
  a_quiet_unlocked: assert property (!PLL_LOCKED |-> SERIAL_LANE_OUT == 4'h0 && !LINK_CLOCK_OUT)
    else $error("serial output before lock");
  a_lock_window: assert property ($rose(ARST_N) |-> ##[LOCK_WAIT:LOCK_MAX] $rose(PLL_LOCKED))
    else $error("lock time out of range");
  a_lock_stays: assert property (PLL_LOCKED |=> PLL_LOCKED)
    else $error("lock dropped");
  a_clock_shape: assert property ($fell(LINK_CLOCK_OUT) |-> !LINK_CLOCK_OUT[*3] ##1 LINK_CLOCK_OUT[*4] ##1 !LINK_CLOCK_OUT)
    else $error("clock lane pattern wrong");
  a_seven_slots: assert property ($fell(LINK_CLOCK_OUT) |-> ##7 $fell(LINK_CLOCK_OUT))
    else $error("frame not seven slots");
endmodule
`default_nettype wire

// ==== verification/lvds_rx_model.sv ====
// Receiver model: deserializes four lanes framed by the clock lane.
// Assumes one slot per rising clk edge.
`timescale 1ns/1ps
`default_nettype none
module lvds_rx_model
  import lvds_tx_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        arst_n,
  input  wire logic [3:0]  lane,
  input  wire logic        link_clk,
  input  wire logic        link_oe,
  output var  logic [27:0] word,
  output var  logic        word_stb
);
  logic [6:0]      clk_hist;
  logic [3:0][6:0] lane_hist;
  // ----
  // Oldest bit is slot 0
  // ----
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_hist  <= 7'h00;
      lane_hist <= '0;
    end else begin
      clk_hist <= {link_clk, clk_hist[6:1]};
      for (int k = 0; k < LANE_COUNT; k++) begin
        lane_hist[k] <= {lane[k], lane_hist[k][6:1]};
      end
    end
  end
  assign word_stb = link_oe && clk_hist == CLOCK_LANE_PATTERN;
  assign word     = lane_hist;
endmodule
`default_nettype wire

// ==== verification/lvds_display_serializer_tx_bench.sv ====
// Self-checking bench for the display link serializer.
// Assumes monitor and receiver model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module lvds_display_serializer_tx_bench;
  import lvds_tx_pkg::*;
  localparam int LOCK_WAIT = 20;
  logic        CLK = 1'b0;
  logic        ARST_N;
  logic        pclk = 1'b0;
  logic [27:0] din;
  logic [27:0] rx_word;
  logic [27:0] last_rx = 28'h0;
  logic [3:0]  lane;
  logic [3:0]  lane_oe;
  logic        lclk;
  logic        lclk_oe;
  logic        locked;
  logic        rx_stb;
  logic [27:0] exp_q[$];
  int          err_count = 0;
  int          checks = 0;
  // ----
  // Clocks and instances
  // ----
  always #20 CLK = ~CLK;
  initial begin
    #7;
    forever #32 pclk = ~pclk;
  end
  lvds_display_serializer_tx #(.LOCK_WAIT(LOCK_WAIT)) uut (.CLK(CLK), .ARST_N(ARST_N),
    .PIXEL_CLOCK_IN(pclk), .PARALLEL_PIXEL_IN(din[23:0]), .LINE_SYNC(din[LINE_SYNC_POS]),
    .FRAME_SYNC(din[FRAME_SYNC_POS]), .PIXEL_DATA_VALID(din[DATA_VALID_POS]),
    .GENERAL_CONTROL_BIT(din[CONTROL_POS]), .SERIAL_LANE_OUT(lane), .SERIAL_LANE_OE(lane_oe),
    .LINK_CLOCK_OUT(lclk), .LINK_CLOCK_OE(lclk_oe), .PLL_LOCKED(locked));
  lvds_rx_model rx (.clk(CLK), .arst_n(ARST_N), .lane(lane), .link_clk(lclk),
    .link_oe(lclk_oe), .word(rx_word), .word_stb(rx_stb));
  // ----
  // Tasks
  // ----
  task automatic fail(input string msg);
    err_count++;
    $display("[ERR] %0t %s", $time, msg);
  endtask
  task automatic chk_word(input logic [27:0] got, input logic [27:0] exp);
    checks++;
    if (got !== exp) fail($sformatf("word %h expected %h", got, exp));
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    checks++;
    if (got !== exp) fail("flag mismatch");
  endtask
  task automatic report_and_stop();
    $display("checks=%0d err_count=%0d", checks, err_count);
    if (err_count == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic send_word(input logic [27:0] w);
    @(negedge CLK);
    din = w;
    exp_q.push_back(w);
    repeat (32) @(negedge CLK);
  endtask
  task automatic wait_lock();
    int n;
    n = 0;
    while (locked !== 1'b1 && n < 200) begin
      @(negedge CLK);
      n++;
    end
    chk_bit(locked, 1'b1);
  endtask
  // ----
  // Observer and sequence
  // ----
  always @(negedge CLK) begin
    if (rx_stb === 1'b1 && rx_word !== last_rx) begin
      last_rx = rx_word;
      if (exp_q.size() == 0) fail("unexpected word");
      else chk_word(rx_word, exp_q.pop_front());
    end
  end
  initial begin
    logic [27:0] w;
    ARST_N = 1'b0;
    void'($urandom(45502));
    din = 28'($urandom());
    exp_q.push_back(din);
    repeat (16) @(negedge CLK);
    ARST_N = 1'b1;
    wait_lock();
    for (int i = 0; i < 6; i++) begin
      w[27:24] = (i < 4) ? 4'(1 << i) : {4{i == 4}};
      w[23:0] = (i == 4) ? 24'hffffff : 24'($urandom());
      send_word(w);
    end
    ARST_N = 1'b0;
    repeat (16) @(negedge CLK);
    chk_bit(lane_oe == 4'h0 && lclk_oe == 1'b0, 1'b1);
    chk_bit(locked, 1'b0);
    ARST_N = 1'b1;
    wait_lock();
    send_word({4'ha, 24'($urandom())});
    chk_bit(exp_q.size() == 0, 1'b1);
    report_and_stop();
  end
  initial begin
    #200000;
    fail("timeout");
    report_and_stop();
  end
endmodule
bind lvds_display_serializer_tx lvds_tx_monitor #(.LOCK_WAIT(LOCK_WAIT)) mon (.CLK(CLK),
  .ARST_N(ARST_N), .PIXEL_CLOCK_IN(PIXEL_CLOCK_IN), .PARALLEL_PIXEL_IN(PARALLEL_PIXEL_IN),
  .LINE_SYNC(LINE_SYNC), .FRAME_SYNC(FRAME_SYNC), .PIXEL_DATA_VALID(PIXEL_DATA_VALID),
  .GENERAL_CONTROL_BIT(GENERAL_CONTROL_BIT), .SERIAL_LANE_OUT(SERIAL_LANE_OUT),
  .SERIAL_LANE_OE(SERIAL_LANE_OE), .LINK_CLOCK_OUT(LINK_CLOCK_OUT),
  .LINK_CLOCK_OE(LINK_CLOCK_OE), .PLL_LOCKED(PLL_LOCKED));
`default_nettype wire
